// File: amp_ctrl_pkg.sv
// Package: constants, types and field layout of the amplifier serial control block
//
// Functional notes
// - Answer address 11010 plus two strap bits
// - Read returns diagnostic one then diagnostic two
// - Control one bit 6 enables load diagnostics
// - Control one bit 5 enables offset detection
// - Bit 4 gain select, bit 0 clip threshold
// - Play needs mute pin high and unmute bit
// - Control two bit 4 low means standby
// - Control two bit 3 selects line-driver thresholds
// - Control two bit 1 selects high efficiency
// - Diagnostic one bit 7 shows thermal warning
// - Diagnostic one bit 6 shows cycle terminated
// - Bit 4 shows permanent versus turn-on diagnostic
// - Bits 3,1,0 flag short load, supply, ground
// - Bit 2 shows open load or offset
// - Diagnostic two bit 7 shows offset active
// - Strap low ignores bus, pins control amplifier
// - Standby pin low always switches off
// - Bus off: pins select mute and mode
// - Offset-stop read valid only in bit 2
// - Each read restarts cycles, shows previous results; code restarts only after a two-byte read
// - Offset must persist from previous read onward
package amp_ctrl_pkg;

  // ****************************************************************
  // Address and field positions
  // ****************************************************************
  localparam logic [4:0] ADDR_FIXED      = 5'h1A;  // Upper five address bits
  localparam int         C1_DIAG_EN      = 6;
  localparam int         C1_OFFSET_EN    = 5;
  localparam int         C1_GAIN_LOW     = 4;
  localparam int         C1_UNMUTE       = 2;
  localparam int         C1_CLIP_HIGH    = 0;
  localparam int         C2_STANDBY_OFF  = 4;
  localparam int         C2_LINE_DRIVER  = 3;
  localparam int         C2_HIGH_EFF     = 1;
  localparam logic [7:0] C1_USED_MASK    = 8'h75;  // Bits kept on write
  localparam logic [7:0] C2_USED_MASK    = 8'h1A;
  localparam logic [7:0] CTRL_RESET      = 8'h00;  // Standby, muted, diagnostics off

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic thermal_warning;   // Die at or above warning level
    logic short_load;        // Per channel faults below
    logic short_supply;
    logic short_ground;
    logic open_load;
    logic offset;
    logic permanent;         // Permanent diagnostic active on channel
  } fault_in_t;

  typedef struct packed {
    logic diag_enable;
    logic offset_enable;
    logic gain_low;
    logic clip_high;
    logic line_driver;
    logic play;
    logic operate;
    logic high_efficiency;
  } amp_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WACK  = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ  = 3'b100,
    ST_RACK  = 3'b101
  } bus_state_t;

endpackage : amp_ctrl_pkg

// File: sync2.sv
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2
  import amp_ctrl_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output var  logic sync_o
);
  logic meta;  // First stage, read only by the second

  // ****************************************************************
  // Two flip-flops in series
  // ****************************************************************
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : sync2
`default_nettype wire

// File: diag_channel.sv
// Per channel diagnostic latch: builds bits 4..0 of one diagnostic byte
`timescale 1ns/1ps
`default_nettype none
module diag_channel
  import amp_ctrl_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       short_load_i,
  input  wire logic       short_supply_i,
  input  wire logic       short_ground_i,
  input  wire logic       open_load_i,
  input  wire logic       offset_i,
  input  wire logic       permanent_i,
  input  wire logic       diag_enable_i,
  input  wire logic       offset_enable_i,
  input  wire logic       restart_i,      // Read finished: publish and restart
  output var  logic [4:0] byte_o          // Bits 4..0 of the diagnostic byte
);
  logic keep_sl;   // Fault seen steady since last restart
  logic keep_sv;
  logic keep_sg;
  logic keep_ol;
  logic keep_of;   // Offset persisted over the whole interval

  // ****************************************************************
  // Persistence tracking over one cycle
  // ****************************************************************
  // A fault only counts if it held throughout the interval; any gap clears it
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i || restart_i)
    begin
      keep_sl <= 1'b1;
      keep_sv <= 1'b1;
      keep_sg <= 1'b1;
      keep_ol <= 1'b1;
      keep_of <= 1'b1;
    end
    else
    begin
      keep_sl <= keep_sl & short_load_i;
      keep_sv <= keep_sv & short_supply_i;
      keep_sg <= keep_sg & short_ground_i;
      keep_ol <= keep_ol & open_load_i;
      keep_of <= offset_enable_i ? (keep_of & offset_i) : 1'b1;
    end
  end

  // ****************************************************************
  // Published byte, taken from the previous cycle
  // ****************************************************************
  // Results only change at a read, so new state needs a second read
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      byte_o <= 5'h00;
    end
    else if (restart_i)
    begin
      byte_o[4] <= permanent_i;
      byte_o[3] <= diag_enable_i & keep_sl & short_load_i;
      byte_o[1] <= diag_enable_i & keep_sv & short_supply_i;
      byte_o[0] <= diag_enable_i & keep_sg & short_ground_i;
      // Offset test overrides open load report while it runs
      byte_o[2] <= offset_enable_i ? (keep_of & offset_i)
                                   : (diag_enable_i & keep_ol & open_load_i);
    end
  end
endmodule : diag_channel
`default_nettype wire

// File: amp_i2c_control_diag.sv
// Top: serial control slave, command decode and diagnostic readback
`timescale 1ns/1ps
`default_nettype none
module amp_i2c_control_diag
  import amp_ctrl_pkg::*;
(
  input  wire logic      clock_i,
  input  wire logic      rst_b_i,
  input  wire logic      scl_i,            // Bus clock, sampled
  input  wire logic      sda_i,            // Bus data level
  output var  logic      sda_o,            // Always low when driving
  output var  logic      sda_oe_o,         // High while pulling data low
  input  wire logic [1:0] addr_sel_i,      // Address select straps
  input  wire logic      bus_enable_i,     // Interface enable strap
  input  wire logic      standby_pin_i,    // Standby pin above operate level
  input  wire logic      standby_he_i,     // Standby pin above high efficiency level
  input  wire logic      mute_pin_i,       // Mute pin above play level
  input  wire fault_in_t ch1_i,            // Channel 1 fault flags
  input  wire fault_in_t ch2_i,            // Channel 2 fault flags
  input  wire logic      diag_done_i,      // Diagnostic cycle terminated
  output var  amp_cmd_t  cmd_o,            // Amplifier controls
  output var  logic [7:0] diag_byte_one_o, // Last published diagnostic bytes
  output var  logic [7:0] diag_byte_two_o
);
  // ****************************************************************
  // Synchronised inputs
  // ****************************************************************
  logic scl_s;        // Synchronised bus clock
  logic sda_s;        // Synchronised bus data
  logic en_s;         // Synchronised strap
  logic sb_s;         // Synchronised standby level
  logic he_s;         // Synchronised high efficiency level
  logic mute_s;       // Synchronised mute level
  logic scl_d;        // Previous bus clock
  logic sda_d;        // Previous bus data

  sync2 u_sync_scl  (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(scl_i),
                     .sync_o(scl_s));
  sync2 u_sync_sda  (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(sda_i),
                     .sync_o(sda_s));
  sync2 u_sync_en   (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(bus_enable_i),
                     .sync_o(en_s));
  sync2 u_sync_sb   (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(standby_pin_i),
                     .sync_o(sb_s));
  sync2 u_sync_he   (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(standby_he_i),
                     .sync_o(he_s));
  sync2 u_sync_mute (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(mute_pin_i),
                     .sync_o(mute_s));

  // ****************************************************************
  // Edge and condition detection
  // ****************************************************************
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // Delayed copies taken from synchronised signals only
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************************************
  // Bus state machine
  // ****************************************************************
  bus_state_t state;        // Protocol phase
  logic [2:0] bit_cnt;      // Bits left after the current one in byte
  logic [7:0] shift;        // Receive shift register
  logic [7:0] tx;           // Transmit shift register
  logic       byte_idx;     // Second byte of a read transfer
  logic       is_read;      // Current transfer reads
  logic       read_done;    // Read ended: second byte sent or master declined
  logic       restart;      // One-cycle pulse at end of a two-byte read
  logic [7:0] ctrl_one;     // control_byte_one register
  logic [7:0] ctrl_two;     // control_byte_two register
  logic       addr_hit;
  logic       master_nack;  // Master declined more data
  logic       addr_lead;    // Start's own clock fall still pending

  assign addr_hit = (shift[7:3] == ADDR_FIXED) && (shift[2:1] == addr_sel_i);

  // Protocol sequencing; a strap low holds the slave idle
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i || !en_s)
    begin
      state       <= ST_IDLE;
      bit_cnt     <= 3'h7;
      shift       <= 8'h00;
      byte_idx    <= 1'b0;
      is_read     <= 1'b0;
      read_done   <= 1'b0;
      master_nack <= 1'b0;
      addr_lead   <= 1'b0;
    end
    else if (start_c)
    begin
      // Repeated start also lands here
      state     <= ST_ADDR;
      bit_cnt   <= 3'h7;
      byte_idx  <= 1'b0;
      addr_lead <= 1'b1;
      read_done <= 1'b0;
    end
    else if (stop_c)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          bit_cnt <= 3'h7;
        end
        ST_ADDR, ST_WRITE:
        begin
          if (scl_rise)
          begin
            shift <= {shift[6:0], sda_s};
          end
          if (scl_fall && addr_lead)
          begin
            addr_lead <= 1'b0;  // Fall closing the start carries no bit
          end
          else if (scl_fall)
          begin
            if (bit_cnt == 3'h0)
            begin
              if (state == ST_ADDR)
              begin
                if (addr_hit)
                begin
                  state   <= ST_WACK;
                  is_read <= shift[0];
                end
                else
                begin
                  state <= ST_IDLE;  // Not ours: stay silent
                end
              end
              else
              begin
                state <= ST_WACK;
              end
            end
            else
            begin
              bit_cnt <= bit_cnt - 3'h1;
            end
          end
        end
        ST_WACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 3'h7;
            if (is_read)
            begin
              state <= ST_READ;
            end
            else if (shift != 8'h00 && byte_idx == 1'b1 && read_done)
            begin
              state <= ST_IDLE;
            end
            else
            begin
              state <= ST_WRITE;
            end
          end
        end
        ST_READ:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 3'h0)
            begin
              state <= ST_RACK;
            end
            else
            begin
              bit_cnt <= bit_cnt - 3'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            master_nack <= sda_s;
          end
          if (scl_fall)
          begin
            bit_cnt <= 3'h7;
            if (byte_idx || master_nack)
            begin
              read_done <= 1'b1;
              state     <= ST_IDLE;
            end
            else
            begin
              byte_idx <= 1'b1;
              state    <= ST_READ;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Write byte counting and control registers
  // ****************************************************************
  logic wr_take;   // Data byte complete in write phase
  logic wr_first;  // Next written byte is control one
  logic wr_second_seen;  // Control two already taken

  assign wr_take = (state == ST_WRITE) && scl_fall && (bit_cnt == 3'h0);

  // Bytes after the second are ignored
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      wr_first <= 1'b1;
      ctrl_one <= CTRL_RESET;
      ctrl_two <= CTRL_RESET;
    end
    else
    begin
      if (start_c)
      begin
        wr_first <= 1'b1;
      end
      else if (wr_take)
      begin
        wr_first <= 1'b0;
      end
      if (wr_take && wr_first)
      begin
        ctrl_one <= shift & C1_USED_MASK;
      end
      else if (wr_take && !wr_first && !wr_second_seen)
      begin
        ctrl_two <= shift & C2_USED_MASK;
      end
    end
  end

  // Track second write byte to stop extra writes
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i || start_c)
    begin
      wr_second_seen <= 1'b0;
    end
    else if (wr_take && !wr_first)
    begin
      wr_second_seen <= 1'b1;
    end
  end

  // ****************************************************************
  // Diagnostic channels and readback
  // ****************************************************************
  logic [4:0] ch1_byte;
  logic [4:0] ch2_byte;
  logic       thermal_pub;   // Thermal bit, published
  logic       done_pub;      // Cycle terminated bit, published

  diag_channel u_ch1 (
    .clock_i         (clock_i),
    .rst_b_i         (rst_b_i),
    .short_load_i    (ch1_i.short_load),
    .short_supply_i  (ch1_i.short_supply),
    .short_ground_i  (ch1_i.short_ground),
    .open_load_i     (ch1_i.open_load),
    .offset_i        (ch1_i.offset),
    .permanent_i     (ch1_i.permanent),
    .diag_enable_i   (ctrl_one[C1_DIAG_EN]),
    .offset_enable_i (ctrl_one[C1_OFFSET_EN]),
    .restart_i       (restart),
    .byte_o          (ch1_byte)
  );

  diag_channel u_ch2 (
    .clock_i         (clock_i),
    .rst_b_i         (rst_b_i),
    .short_load_i    (ch2_i.short_load),
    .short_supply_i  (ch2_i.short_supply),
    .short_ground_i  (ch2_i.short_ground),
    .open_load_i     (ch2_i.open_load),
    .offset_i        (ch2_i.offset),
    .permanent_i     (ch2_i.permanent),
    .diag_enable_i   (ctrl_one[C1_DIAG_EN]),
    .offset_enable_i (ctrl_one[C1_OFFSET_EN]),
    .restart_i       (restart),
    .byte_o          (ch2_byte)
  );

  // Restart pulse when the acknowledge slot of the second diagnostic byte ends
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      restart     <= 1'b0;
      thermal_pub <= 1'b0;
      done_pub    <= 1'b0;
    end
    else
    begin
      restart <= (state == ST_RACK) && scl_fall && byte_idx;
      if (restart)
      begin
        thermal_pub <= ch1_i.thermal_warning;
        done_pub    <= diag_done_i;
      end
    end
  end

  // Assembled bytes; don't-care bits stay zero
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      diag_byte_one_o <= 8'h00;
      diag_byte_two_o <= 8'h00;
    end
    else
    begin
      diag_byte_one_o <= {thermal_pub, done_pub, 1'b0, ch1_byte};
      diag_byte_two_o <= {ctrl_one[C1_OFFSET_EN], 2'b00, ch2_byte};
    end
  end

  // Transmit shift loads on entering each read byte
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      tx <= 8'h00;
    end
    else if (state == ST_WACK && scl_fall && is_read)
    begin
      tx <= diag_byte_one_o;
    end
    else if (state == ST_RACK && scl_fall && !byte_idx)
    begin
      tx <= diag_byte_two_o;
    end
    else if (state == ST_READ && scl_fall)
    begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  // ****************************************************************
  // Data line drive
  // ****************************************************************
  // Open drain: only ever pulls low; released for every one
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      case (state)
        ST_WACK:  sda_oe_o <= 1'b1;
        ST_READ:  sda_oe_o <= ~tx[7];
        default:  sda_oe_o <= 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Amplifier command decode
  // ****************************************************************
  // Pin standby low wins over the bus standby, unmute and high efficiency bits; other controls follow the bus while the strap is high, cleared while it is low
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      cmd_o <= '0;
    end
    else if (en_s)
    begin
      cmd_o.diag_enable     <= ctrl_one[C1_DIAG_EN];
      cmd_o.offset_enable   <= ctrl_one[C1_OFFSET_EN];
      cmd_o.gain_low        <= ctrl_one[C1_GAIN_LOW];
      cmd_o.clip_high       <= ctrl_one[C1_CLIP_HIGH];
      cmd_o.line_driver     <= ctrl_two[C2_LINE_DRIVER];
      cmd_o.operate         <= sb_s & ctrl_two[C2_STANDBY_OFF];
      cmd_o.play            <= sb_s & ctrl_two[C2_STANDBY_OFF]
                               & mute_s & ctrl_one[C1_UNMUTE];
      cmd_o.high_efficiency <= sb_s & ctrl_two[C2_HIGH_EFF];
    end
    else
    begin
      cmd_o.diag_enable     <= 1'b0;
      cmd_o.offset_enable   <= 1'b0;
      cmd_o.gain_low        <= 1'b0;
      cmd_o.clip_high       <= 1'b0;
      cmd_o.line_driver     <= 1'b0;
      cmd_o.operate         <= sb_s;
      cmd_o.play            <= sb_s & mute_s;
      cmd_o.high_efficiency <= sb_s & he_s;
    end
  end
endmodule : amp_i2c_control_diag
`default_nettype wire

// File: amp_i2c_control_diag_sva.sv
// Checker of the control block's port behaviour
`timescale 1ns/1ps
`default_nettype none
module amp_i2c_control_diag_sva
  import amp_ctrl_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_b_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       bus_enable_i,
  input wire logic       standby_pin_i,
  input wire logic       mute_pin_i,
  input wire amp_cmd_t   cmd_o,
  input wire logic [7:0] diag_byte_one_o,
  input wire logic [7:0] diag_byte_two_o
);
  // ****************************************************************
  // Properties: six cycles cover the input synchronisers
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_ack_pull_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  a_drive_in_low: assert property ($rose(sda_oe_o) |-> !scl_i ##[1:12] scl_i)
    else $error("data drive not inside clock low phase");
  a_strap_quiet: assert property ((!bus_enable_i) [*6] |-> !sda_oe_o)
    else $error("bus answered with strap low");
  a_standby_off: assert property ((!standby_pin_i) [*6] |->
    !cmd_o.operate && !cmd_o.play && !cmd_o.high_efficiency)
    else $error("amplifier on with standby pin low");
  a_mute_holds: assert property ((!mute_pin_i) [*6] |-> !cmd_o.play)
    else $error("play with mute pin low");
  a_pin_play: assert property ((!bus_enable_i && standby_pin_i && mute_pin_i) [*6]
    |-> cmd_o.play && cmd_o.operate)
    else $error("pins did not select play");
  a_diag_hold: assert property (scl_i [*8] |->
    $stable(diag_byte_one_o) && $stable(diag_byte_two_o))
    else $error("diagnostic bytes moved outside a read");
  a_diag_blank: assert property (diag_byte_one_o[5] == 1'b0 &&
    diag_byte_two_o[6:5] == 2'b00)
    else $error("unused diagnostic bits set");
endmodule : amp_i2c_control_diag_sva
bind amp_i2c_control_diag amp_i2c_control_diag_sva amp_i2c_control_diag_sva_inst (
  .clock_i, .rst_b_i, .scl_i, .sda_o, .sda_oe_o, .bus_enable_i, .standby_pin_i,
  .mute_pin_i, .cmd_o, .diag_byte_one_o, .diag_byte_two_o);
`default_nettype wire

// File: i2c_master_model.sv
// Bus master model that writes control bytes and reads diagnostic bytes
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
  input  wire logic clock_i,
  input  wire logic sda_i,     // Resolved data wire
  output var  logic scl_o,     // Stands high between frames
  output var  logic sda_low_o  // High pulls the data wire low
);
  initial scl_o = 1'b1;
  initial sda_low_o = 1'b0;
  // ****************************************************************
  // Bit, byte and frame tasks: 80 ns per clock half
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_low_o <= ~b;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    s = sda_i;
    tick(4);
    scl_o <= 1'b0;
    tick(4);
  endtask : bit_io
  // Eight bits, top bit first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask : byte_io
  task automatic frame(input logic [7:0] adr, input logic [15:0] wd,
                       output logic [15:0] rd, output logic [2:0] ack);
    logic [7:0] q;
    sda_low_o <= 1'b1;
    tick(8);
    scl_o <= 1'b0;
    tick(4);
    byte_io(adr, 1'b1, q, ack[2]);
    // Read: master acknowledges both bytes
    if (adr[0])
    begin
      byte_io(8'hFF, 1'b0, rd[15:8], ack[1]);
      byte_io(8'hFF, 1'b0, rd[7:0], ack[0]);
    end
    else
    begin
      rd = 16'h0000;
      byte_io(wd[15:8], 1'b1, q, ack[1]);
      byte_io(wd[7:0], 1'b1, q, ack[0]);
    end
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    sda_low_o <= 1'b0;
    tick(8);
  endtask : frame
endmodule : i2c_master_model
`default_nettype wire

// File: test_amp_i2c_control_diag.sv
// Self-checking bench of the amplifier serial control block
`timescale 1ns/1ps
`default_nettype none
module test_amp_i2c_control_diag
  import amp_ctrl_pkg::*;
;
  logic        clock_i, rst_b_i, scl, sda_low, sda_out, sda_oe, sda;
  logic [1:0]  addr_sel;
  logic        bus_enable, standby_pin, standby_he, mute_pin, diag_done;
  fault_in_t   ch1, ch2;
  amp_cmd_t    cmd;
  logic [7:0]  db1, db2, c1, c2;
  logic [15:0] rd, seen, exp_rd;
  logic [2:0]  ack;
  logic [17:0] notes[$];   // Kind in top two bits, value below
  logic [17:0] note;
  int          miscompares, total_checks, cycles;
  event        check_ev;
  string       names[4] = '{"cmd", "read", "ack", "pins"};
  // Pulled-up wire: low when either side pulls
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  always #5 clock_i = ~clock_i;
  amp_i2c_control_diag amp_i2c_control_diag_inst (.clock_i, .rst_b_i, .scl_i(scl),
    .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe), .addr_sel_i(addr_sel),
    .bus_enable_i(bus_enable), .standby_pin_i(standby_pin), .standby_he_i(standby_he),
    .mute_pin_i(mute_pin), .ch1_i(ch1), .ch2_i(ch2), .diag_done_i(diag_done),
    .cmd_o(cmd), .diag_byte_one_o(db1), .diag_byte_two_o(db2));
  i2c_master_model i2c_master_model_inst (.clock_i, .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low));
  // ****************************************************************
  // Checking side: oldest note against what the block shows
  // ****************************************************************
  always @(check_ev)
    while (notes.size() > 0)
    begin
      note = notes.pop_front();
      case (note[17:16])
        2'd0: seen = {8'h00, cmd};
        2'd1: seen = rd;
        2'd2: seen = {13'h0000, ack};
        default: seen = {13'h0000, cmd[2:0]};
      endcase
      total_checks++;
      if (seen !== note[15:0])
      begin
        miscompares++;
        $display("[ERR] %s expected %h seen %h", names[note[17:16]], note[15:0], seen);
      end
    end
  // Hang guard well above the longest run
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  // ****************************************************************
  // Driving side
  // ****************************************************************
  task automatic note_it(input logic [1:0] k, input logic [15:0] v);
    notes.push_back({k, v});
  endtask : note_it
  // Sync chain latency covered before looking
  task automatic settle_check;
    repeat (8) @(posedge clock_i);
    -> check_ev;
    @(posedge clock_i);
  endtask : settle_check
  task automatic bus(input logic [7:0] a, input logic [15:0] w);
    i2c_master_model_inst.frame(a, w, rd, ack);
  endtask : bus
  function automatic logic [7:0] dx(input logic [2:0] hi, input fault_in_t f);
    return {hi, f.permanent, f.short_load, f.offset, f.short_supply, f.short_ground};
  endfunction : dx
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial
  begin
    void'($urandom(32'h7D145305));
    {clock_i, rst_b_i, bus_enable, standby_pin, standby_he, mute_pin} = 6'b001100;
    {addr_sel, diag_done} = {2'($urandom), 1'b1};
    ch1 = fault_in_t'($urandom);
    ch2 = fault_in_t'($urandom);
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    note_it(0, 16'h0000);
    settle_check();
    // Random control bytes, standby bit forced off
    repeat (6)
    begin
      c1 = 8'($urandom);
      c2 = 8'($urandom) | 8'h10;
      mute_pin <= 1'($urandom);
      bus({ADDR_FIXED, addr_sel, 1'b0}, {c1, c2});
      note_it(2, 16'h0000);
      note_it(0, {8'h00, c1[6:4], c1[0], c2[3], c1[2] & mute_pin, 1'b1, c2[1]});
      settle_check();
    end
    // Foreign addresses: no answer, nothing changes
    bus({ADDR_FIXED ^ 5'h01, addr_sel, 1'b0}, 16'hFFFF);
    note_it(2, 16'h0007);
    bus({ADDR_FIXED, ~addr_sel, 1'b0}, 16'hFFFF);
    note_it(2, 16'h0007);
    note_it(0, {8'h00, cmd_exp()});
    settle_check();
    standby_pin <= 1'b0;
    note_it(3, 16'h0000);
    settle_check();
    standby_pin <= 1'b1;
    mute_pin <= 1'b1;
    bus({ADDR_FIXED, addr_sel, 1'b0}, 16'h6410);
    exp_rd = {dx({ch1.thermal_warning, 2'b10}, ch1), dx(3'b100, ch2)};
    // Five reads: results trail the faults by one read
    for (int i = 0; i < 5; i++)
    begin
      bus({ADDR_FIXED, addr_sel, 1'b1}, 16'h0000);
      note_it(2, 16'h0000);
      if (i == 0)
        note_it(1, 16'h0080);
      if (i == 2 || i == 3)
        note_it(1, exp_rd);
      if (i == 4)
        note_it(1, 16'h4080);
      settle_check();
      if (i == 2)
        {ch1, ch2} <= 14'h0000;
    end
    bus({ADDR_FIXED, addr_sel, 1'b0}, 16'h0000);
    note_it(0, 16'h0000);
    settle_check();
    bus_enable <= 1'b0;
    bus({ADDR_FIXED, addr_sel, 1'b0}, 16'h0000);
    note_it(2, 16'h0007);
    for (int i = 0; i < 8; i++)
    begin
      {standby_pin, standby_he, mute_pin} <= {i[2], i[2] & i[1], i[0]};
      note_it(3, {13'h0000, i[2] & i[0], i[2], i[2] & i[1]});
      settle_check();
    end
    complete_run();
  end
  function automatic logic [7:0] cmd_exp();
    return {c1[6:4], c1[0], c2[3], c1[2] & mute_pin, 1'b1, c2[1]};
  endfunction : cmd_exp
endmodule : test_amp_i2c_control_diag
`default_nettype wire
